// >>> dtmoc_regs.svh
/*
  Constants of the dual timer output and mode control block: reset values
  and glitch filter widths with their derived cycle counts.
  Assumes a 125 MHz system clock.
*/
`ifndef DTMOC_REGS_SVH
`define DTMOC_REGS_SVH

// System clock period in ns
`define DTMOC_CLK_PERIOD_NS 8

// Glitch widths rejected for each submode code in pulse-measure mode
`define DTMOC_GLITCH0_NS    8
`define DTMOC_GLITCH1_NS    1000
`define DTMOC_GLITCH2_NS    2000
`define DTMOC_GLITCH3_NS    4000

// Least times round up to whole clock cycles
`define DTMOC_NS2CYC(t) \
  (((t) + `DTMOC_CLK_PERIOD_NS - 1) / `DTMOC_CLK_PERIOD_NS)
`define DTMOC_GLITCH0_CYC   `DTMOC_NS2CYC(`DTMOC_GLITCH0_NS)
`define DTMOC_GLITCH1_CYC   `DTMOC_NS2CYC(`DTMOC_GLITCH1_NS)
`define DTMOC_GLITCH2_CYC   `DTMOC_NS2CYC(`DTMOC_GLITCH2_NS)
`define DTMOC_GLITCH3_CYC   `DTMOC_NS2CYC(`DTMOC_GLITCH3_NS)

// Width of the filter stability counter
`define DTMOC_FILT_CNT_W    10

// Reset values of enables, flags and outputs
`define DTMOC_RST_ENABLE    1'b0
`define DTMOC_RST_FLAG      1'b0
`define DTMOC_RST_OUT       1'b0

`endif

// >>> dtmoc_pkg.sv
/*
  Types of the dual timer output and mode control block.
  Assumes the constants header is compiled alongside.
*/
package dtmoc_pkg;

  // Combine function in waveform mode
  typedef enum logic [1:0] {
    DTMOC_FN_AND  = 2'h0,
    DTMOC_FN_OR   = 2'h1,
    DTMOC_FN_NOR  = 2'h2,
    DTMOC_FN_NAND = 2'h3
  } dtmoc_combine_t;

  // Edge choice in pulse-measure mode (same field)
  typedef enum logic [1:0] {
    DTMOC_EDGE_FALL = 2'h0,
    DTMOC_EDGE_RISE = 2'h1,
    DTMOC_EDGE_BOTH = 2'h2,
    DTMOC_EDGE_ANY  = 2'h3
  } dtmoc_edge_t;

  // Submode in waveform mode
  typedef enum logic [1:0] {
    DTMOC_SUB_NORMAL = 2'h0,
    DTMOC_SUB_ALT    = 2'h1,
    DTMOC_SUB_FORCE0 = 2'h2,
    DTMOC_SUB_FORCE1 = 2'h3
  } dtmoc_submode_t;

endpackage

// >>> dtmoc_filt_if.sv
/*
  Carrier between the control block and its glitch filter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface dtmoc_filt_if;
  logic       rawIn;     // Selected edge input
  logic [1:0] widthSel;  // Glitch width code
  logic       filtOut;   // Filtered level

  modport ctrl (output rawIn, output widthSel, input filtOut);
  modport filt (input rawIn, input widthSel, output filtOut);
endinterface

// >>> dtmoc_glitch_filter.sv
/*
  Glitch filter: passes a level change only once the input has held the
  new level for the selected number of cycles.
  Assumes the input is synchronous to clk.
*/
`timescale 1ns/100ps
`include "dtmoc_regs.svh"
module dtmoc_glitch_filter (
  input wire logic clk,             // System clock
  input wire logic reset,           // Synchronous reset, active high
  dtmoc_filt_if.filt fi             // Raw input, width code, filtered out
);
  import dtmoc_pkg::*;

  logic [`DTMOC_FILT_CNT_W-1:0] holdCnt_reg;
  logic [`DTMOC_FILT_CNT_W-1:0] thresh;
  logic                         filt_reg;

  // Width code to hold count
  always_comb begin
    unique case (fi.widthSel)
      2'h0: thresh = `DTMOC_FILT_CNT_W'(`DTMOC_GLITCH0_CYC);
      2'h1: thresh = `DTMOC_FILT_CNT_W'(`DTMOC_GLITCH1_CYC);
      2'h2: thresh = `DTMOC_FILT_CNT_W'(`DTMOC_GLITCH2_CYC);
      2'h3: thresh = `DTMOC_FILT_CNT_W'(`DTMOC_GLITCH3_CYC);
    endcase
  end

  // Count cycles of disagreement, accept after the threshold
  always_ff @(posedge clk) begin
    if (reset) begin
      holdCnt_reg <= '0;
      filt_reg    <= `DTMOC_RST_OUT;
    end else if (fi.rawIn == filt_reg) begin
      holdCnt_reg <= '0;
    end else if (holdCnt_reg + 1'b1 >= thresh) begin // RULE6
      holdCnt_reg <= '0;
      filt_reg    <= fi.rawIn;
    end else begin
      holdCnt_reg <= holdCnt_reg + 1'b1;
    end
  end

  assign fi.filtOut = filt_reg;

  a_filter_holds: assert property (@(posedge clk) disable iff (reset) // RULE6
    (fi.rawIn != filt_reg) && (holdCnt_reg + 1'b1 < thresh)
    |=> $stable(filt_reg))
    else $error("Filtered level changed before the glitch width");

endmodule // dtmoc_glitch_filter

// >>> dtmoc_ctrl.sv
/*
  Mode and output control for a linked 8-bit and 16-bit timer pair.
  Waveform mode: output combining, alternating or normal running, forced
  16-bit output. Pulse-measure mode: edge select, glitch filter, pin route.
  Assumes counter engines supply terminal-count pulses and consume the
  enables and the edge pulse; control fields are held by software.
  // Operation
  // [RULE1] Waveform mode merges outputs by AND/OR/NOR/NAND
  // [RULE2] Pulse mode: same field picks edge polarity
  // [RULE3] Waveform submode picks alternating or normal
  // [RULE4] Selecting normal ends alternating operation
  // [RULE5] Codes 10/11 force 16-bit output 0/1
  // [RULE6] Pulse mode: submode sets glitch width
  // [RULE7] Pulse mode: edge input pin selectable
  // [RULE8] Codes 00 normal, 01 alternating; reset normal
  // [RULE9] Alternating swaps enables; timeouts set on terminal
  // [RULE10] Rising edge sets flag; write-one clears
  // [RULE11] 8-bit output starts at programmed initial level
*/
`timescale 1ns/100ps
`include "dtmoc_regs.svh"
module dtmoc_ctrl (
  input  wire logic                  clk,          // System clock
  input  wire logic                  reset,        // Sync reset, high
  input  wire logic                  modeDemod,    // 1 pulse-measure mode
  input  wire dtmoc_pkg::dtmoc_combine_t logicSel, // Combine fn / edge
  input  wire dtmoc_pkg::dtmoc_submode_t submode,  // Submode / glitch
  input  wire logic                  initLevel8,   // 8-bit start level
  input  wire logic                  initLevel16,  // 16-bit start level
  input  wire logic                  pinSel,       // 1 use edge_input_pin
  input  wire logic                  edgeInputPin, // Port pin input
  input  wire logic                  altEdgeIn,    // Other edge source
  input  wire logic                  en8WrStb,     // Write 8-bit enable
  input  wire logic                  en8WrVal,     // Value written
  input  wire logic                  en16WrStb,    // Write 16-bit enable
  input  wire logic                  en16WrVal,    // Value written
  input  wire logic                  tc8,          // 8-bit terminal count
  input  wire logic                  tc16,         // 16-bit terminal count
  input  wire logic                  to8ClrStb,    // Clear 8-bit timeout
  input  wire logic                  to16ClrStb,   // Clear 16-bit timeout
  input  wire logic                  riseClrStb,   // Clear rising flag
  input  wire logic                  fallClrStb,   // Clear falling flag
  output logic                       en8,          // 8-bit timer enable
  output logic                       en16,         // 16-bit timer enable
  output logic                       timeout8,     // 8-bit timeout flag
  output logic                       timeout16,    // 16-bit timeout flag
  output logic                       riseSeen,     // Rising edge flag
  output logic                       fallSeen,     // Falling edge flag
  output logic                       edgePulse,    // Selected edge pulse
  output logic                       out8,         // 8-bit timer output
  output logic                       out16,        // 16-bit timer output
  output logic                       combOut       // Combined output
);
  import dtmoc_pkg::*;

  logic en8_reg, en8_next, en16_reg, en16_next;
  logic out8_reg, out16_reg, comb_reg;
  logic to8_reg, to16_reg, rise_reg, fall_reg, edge_reg;
  logic altOn, tc8Hit, tc16Hit, filtPrev_reg, riseDet, fallDet, edgeSel;
  dtmoc_edge_t edgeMode;

  dtmoc_filt_if fif ();

  // Alternating run only in waveform mode with its submode code
  assign altOn   = !modeDemod && (submode == DTMOC_SUB_ALT); // RULE3 RULE4
  assign tc8Hit  = tc8 && en8_reg;
  assign tc16Hit = tc16 && en16_reg;

  // Enable next values: hardware swap first, then software write, which wins
  always_comb begin
    en8_next  = en8_reg;
    en16_next = en16_reg;
    if (altOn && tc8Hit) begin // RULE9
      en8_next  = 1'b0;
      en16_next = 1'b1;
    end else if (altOn && tc16Hit) begin // RULE9
      en16_next = 1'b0;
      en8_next  = 1'b1;
    end
    if (en8WrStb) begin
      en8_next = en8WrVal;
    end
    if (en16WrStb) begin
      en16_next = en16WrVal;
    end
  end

  // Enable registers
  always_ff @(posedge clk) begin
    if (reset) begin
      en8_reg  <= `DTMOC_RST_ENABLE; // RULE8
      en16_reg <= `DTMOC_RST_ENABLE; // RULE8
    end else begin
      en8_reg  <= en8_next;
      en16_reg <= en16_next;
    end
  end

  // Timeout flags: terminal count sets, write-one clears, set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      to8_reg  <= `DTMOC_RST_FLAG;
      to16_reg <= `DTMOC_RST_FLAG;
    end else begin
      to8_reg  <= tc8Hit  || (to8_reg  && !to8ClrStb);  // RULE9
      to16_reg <= tc16Hit || (to16_reg && !to16ClrStb); // RULE9
    end
  end

  // 8-bit output: idle at opposite level, start level, toggle on count
  always_ff @(posedge clk) begin
    if (reset) begin
      out8_reg <= `DTMOC_RST_OUT;
    end else if (!en8_next) begin
      out8_reg <= !initLevel8;
    end else if (!en8_reg) begin
      out8_reg <= initLevel8; // RULE11
    end else if (tc8Hit) begin
      out8_reg <= !out8_reg;
    end
  end

  // 16-bit output: forced codes override the counting behaviour
  always_ff @(posedge clk) begin
    if (reset) begin
      out16_reg <= `DTMOC_RST_OUT;
    end else if (!modeDemod && submode == DTMOC_SUB_FORCE0) begin
      out16_reg <= 1'b0; // RULE5
    end else if (!modeDemod && submode == DTMOC_SUB_FORCE1) begin
      out16_reg <= 1'b1; // RULE5
    end else if (!en16_next) begin
      out16_reg <= !initLevel16;
    end else if (!en16_reg) begin
      out16_reg <= initLevel16;
    end else if (tc16Hit) begin
      out16_reg <= !out16_reg;
    end
  end

  // Combine the two timer outputs by the selected function
  always_ff @(posedge clk) begin
    if (reset) begin
      comb_reg <= `DTMOC_RST_OUT;
    end else begin
      unique case (logicSel) // RULE1
        DTMOC_FN_AND:  comb_reg <= out8_reg & out16_reg;
        DTMOC_FN_OR:   comb_reg <= out8_reg | out16_reg;
        DTMOC_FN_NOR:  comb_reg <= !(out8_reg | out16_reg);
        DTMOC_FN_NAND: comb_reg <= !(out8_reg & out16_reg);
      endcase
    end
  end

  // Edge source routing and glitch width to the filter
  assign fif.rawIn    = pinSel ? edgeInputPin : altEdgeIn; // RULE7
  assign fif.widthSel = submode;                           // RULE6

  dtmoc_glitch_filter u_filter (
    .clk   (clk),
    .reset (reset),
    .fi    (fif.filt)
  );

  // Edge detection on the filtered level
  always_ff @(posedge clk) begin
    if (reset) begin
      filtPrev_reg <= `DTMOC_RST_OUT;
    end else begin
      filtPrev_reg <= fif.filtOut;
    end
  end

  assign riseDet  = modeDemod && fif.filtOut && !filtPrev_reg;
  assign fallDet  = modeDemod && !fif.filtOut && filtPrev_reg;
  assign edgeMode = dtmoc_edge_t'(logicSel);

  // Edge polarity chosen by the shared combine field
  always_comb begin
    unique case (edgeMode) // RULE2
      DTMOC_EDGE_FALL: edgeSel = fallDet;
      DTMOC_EDGE_RISE: edgeSel = riseDet;
      DTMOC_EDGE_BOTH: edgeSel = riseDet || fallDet;
      DTMOC_EDGE_ANY:  edgeSel = riseDet || fallDet;
    endcase
  end

  // Edge pulse and sticky edge flags, set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      edge_reg <= 1'b0;
      rise_reg <= `DTMOC_RST_FLAG;
      fall_reg <= `DTMOC_RST_FLAG;
    end else begin
      edge_reg <= edgeSel;
      rise_reg <= riseDet || (rise_reg && !riseClrStb); // RULE10
      fall_reg <= fallDet || (fall_reg && !fallClrStb);
    end
  end

  assign en8       = en8_reg;
  assign en16      = en16_reg;
  assign timeout8  = to8_reg;
  assign timeout16 = to16_reg;
  assign riseSeen  = rise_reg;
  assign fallSeen  = fall_reg;
  assign edgePulse = edge_reg;
  assign out8      = out8_reg;
  assign out16     = out16_reg;
  assign combOut   = comb_reg;

  a_combine_nand: assert property (@(posedge clk) disable iff (reset) // RULE1
    logicSel == DTMOC_FN_NAND |=>
    comb_reg == !($past(out8_reg) && $past(out16_reg)))
    else $error("Combined output is not the NAND of the timer outputs");

  a_edge_rise: assert property (@(posedge clk) disable iff (reset) // RULE2
    edgeMode == DTMOC_EDGE_RISE |=> edge_reg == $past(riseDet))
    else $error("Edge pulse does not follow the rising edge choice");

  a_alt_swap: assert property (@(posedge clk) disable iff (reset) // RULE3
    altOn && tc8Hit && !en8WrStb && !en16WrStb
    |=> !en8_reg && en16_reg)
    else $error("Alternating run did not hand over to the 16-bit timer");

  a_normal_hold: assert property (@(posedge clk) disable iff (reset) // RULE4
    submode == DTMOC_SUB_NORMAL && !en8_reg && !en8WrStb
    |=> !en8_reg)
    else $error("Normal submode re-enabled the 8-bit timer");

  a_force_low: assert property (@(posedge clk) disable iff (reset) // RULE5
    !modeDemod && submode == DTMOC_SUB_FORCE0 |=> !out16_reg)
    else $error("16-bit output not forced low");

  a_force_high: assert property (@(posedge clk) disable iff (reset) // RULE5
    !modeDemod && submode == DTMOC_SUB_FORCE1 |=> out16_reg)
    else $error("16-bit output not forced high");

  a_reset_normal: assert property (@(posedge clk) // RULE8
    $past(reset) |-> !en8_reg && !en16_reg)
    else $error("Enables not cleared by reset");

  a_timeout_set: assert property (@(posedge clk) disable iff (reset) // RULE9
    tc16Hit |=> to16_reg)
    else $error("16-bit timeout flag not set at terminal count");

  a_rise_sticky: assert property (@(posedge clk) disable iff (reset) // RULE10
    rise_reg && !riseClrStb |=> rise_reg)
    else $error("Rising edge flag lost without a clear");

  a_start_level: assert property (@(posedge clk) disable iff (reset) // RULE11
    $rose(en8_reg) |-> out8_reg == $past(initLevel8))
    else $error("8-bit output did not start at the initial level");

endmodule // dtmoc_ctrl

// >>> dtmoc_ir_source.sv
/*
  Model of the infrared receiver that feeds the edge input pin.
  Assumes the bench calls drive at a falling clock edge.
*/
`timescale 1ns/100ps
module dtmoc_ir_source (
  input  wire logic clk,      // System clock
  output logic      pinLevel  // Receiver level on the pin
);
  initial pinLevel = 1'b0;

  // Holds a level for n cycles, changing only at falling edges
  task automatic drive(input logic lvl, input int n);
    @(negedge clk);
    pinLevel = lvl;
    repeat (n - 1) @(negedge clk);
  endtask
endmodule // dtmoc_ir_source

// >>> dtmoc_ctrl_tb.sv
/*
  Self-checking bench of the timer mode and output control block.
  Assumes the package and constants header are compiled first.
*/
`timescale 1ns/100ps
module dtmoc_ctrl_tb;
  import dtmoc_pkg::*;
  logic           clk, reset, modeDemod, initLevel8, initLevel16, pinSel;
  logic           altEdgeIn, en8WrStb, en8WrVal, en16WrStb, en16WrVal;
  logic           tc8, tc16, to8ClrStb, to16ClrStb, riseClrStb, fallClrStb;
  logic           edgeInputPin, en8, en16, timeout8, timeout16, riseSeen;
  logic           fallSeen, edgePulse, out8, out16, combOut;
  logic [31:0]    rnd;
  dtmoc_combine_t logicSel;
  dtmoc_submode_t submode;
  int             bad_count, cmp_count, pulses, pr, n;

  dtmoc_ctrl i_dtmoc_ctrl (.clk(clk), .reset(reset), .modeDemod(modeDemod),
    .logicSel(logicSel), .submode(submode), .initLevel8(initLevel8),
    .initLevel16(initLevel16), .pinSel(pinSel), .edgeInputPin(edgeInputPin),
    .altEdgeIn(altEdgeIn), .en8WrStb(en8WrStb), .en8WrVal(en8WrVal),
    .en16WrStb(en16WrStb), .en16WrVal(en16WrVal), .tc8(tc8), .tc16(tc16),
    .to8ClrStb(to8ClrStb), .to16ClrStb(to16ClrStb), .riseClrStb(riseClrStb),
    .fallClrStb(fallClrStb), .en8(en8), .en16(en16), .timeout8(timeout8),
    .timeout16(timeout16), .riseSeen(riseSeen), .fallSeen(fallSeen),
    .edgePulse(edgePulse), .out8(out8), .out16(out16), .combOut(combOut));
  dtmoc_ir_source i_dtmoc_ir_source (.clk(clk), .pinLevel(edgeInputPin));

  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts selected-edge pulses
  always @(posedge clk) if (edgePulse === 1'b1) pulses <= pulses + 1;

  // Reference combining function
  function automatic logic comb(input int f, input logic a, input logic b);
    case (f)
      0: return a & b;
      1: return a | b;
      2: return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction

  task automatic chk(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chkn(input string nm, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // One-cycle strobe on a control input
  task automatic strobe(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {reset, modeDemod, pinSel, altEdgeIn, en8WrStb, en8WrVal, en16WrStb,
     en16WrVal, tc8, tc16, to8ClrStb, to16ClrStb, riseClrStb} = '0;
    fallClrStb = 1'b0;
    logicSel = DTMOC_FN_AND;
    submode = DTMOC_SUB_NORMAL;
    bad_count = 0;
    cmp_count = 0;
    pulses = 0;
    rnd = $urandom(32'h0000_fa80);
    initLevel8 = rnd[0];
    initLevel16 = rnd[1];
    reset = 1'b1;
    cyc(5);
    chk("en8 reset", 1'b0, en8);
    chk("timeout16 reset", 1'b0, timeout16);
    reset = 1'b0;
    // Output combining of idle outputs, all four functions
    for (int f = 0; f < 4; f++) begin
      rnd = $urandom;
      initLevel8 = rnd[0];
      initLevel16 = rnd[1];
      logicSel = dtmoc_combine_t'(f);
      cyc(3);
      chk("out8 idle", ~initLevel8, out8);
      chk("out16 idle", ~initLevel16, out16);
      chk("combOut", comb(f, ~initLevel8, ~initLevel16), combOut);
    end
    // Forced 16-bit output codes
    for (int k = 2; k < 4; k++) begin
      submode = dtmoc_submode_t'(k);
      cyc(3);
      chk("out16 forced", k[0], out16);
      chk("combOut forced", comb(3, ~initLevel8, k[0]), combOut);
    end
    // Alternating walk
    submode = DTMOC_SUB_ALT;
    en8WrVal = 1'b1;
    strobe(en8WrStb);
    chk("en8 start", 1'b1, en8);
    chk("out8 start", initLevel8, out8);
    strobe(tc8);
    chk("en8 swap", 1'b0, en8);
    chk("en16 swap", 1'b1, en16);
    chk("timeout8", 1'b1, timeout8);
    chk("out16 start", initLevel16, out16);
    strobe(tc16);
    chk("en8 back", 1'b1, en8);
    chk("timeout16", 1'b1, timeout16);
    strobe(to8ClrStb);
    chk("timeout8 clear", 1'b0, timeout8);
    // Normal operation stops the swapping
    submode = DTMOC_SUB_NORMAL;
    strobe(tc8);
    chk("en8 kept", 1'b1, en8);
    chk("en16 kept", 1'b0, en16);
    chk("out8 toggled", ~initLevel8, out8);
    en8WrVal = 1'b0;
    strobe(en8WrStb);
    // Pulse-measure mode: edge selection per code
    modeDemod = 1'b1;
    pinSel = 1'b1;
    cyc(4);
    for (int e = 0; e < 4; e++) begin
      logicSel = dtmoc_combine_t'(e);
      pulses = 0;
      i_dtmoc_ir_source.drive(1'b1, 6);
      pr = pulses;
      i_dtmoc_ir_source.drive(1'b0, 6);
      chkn("rise pulses", (e != 0) ? 1 : 0, pr);
      chkn("fall pulses", (e != 1) ? 1 : 0, pulses - pr);
    end
    chk("riseSeen", 1'b1, riseSeen);
    strobe(riseClrStb);
    chk("riseSeen clear", 1'b0, riseSeen);
    chk("fallSeen kept", 1'b1, fallSeen);
    strobe(fallClrStb);
    // Glitch shorter than 125 cycles is rejected
    submode = DTMOC_SUB_ALT;
    pulses = 0;
    i_dtmoc_ir_source.drive(1'b1, 60);
    i_dtmoc_ir_source.drive(1'b0, 200);
    chkn("glitch pulses", 0, pulses);
    i_dtmoc_ir_source.drive(1'b1, 1);
    n = 1;
    while (riseSeen !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      conclude();
    end
    chk("filter delay", 1'b1, n >= 125 && n <= 128);
    i_dtmoc_ir_source.drive(1'b0, 200);
    // Alternate source chosen, pin ignored
    submode = DTMOC_SUB_NORMAL;
    pinSel = 1'b0;
    cyc(4);
    pulses = 0;
    i_dtmoc_ir_source.drive(1'b1, 6);
    i_dtmoc_ir_source.drive(1'b0, 6);
    chkn("pin ignored", 0, pulses);
    altEdgeIn = 1'b1;
    cyc(6);
    altEdgeIn = 1'b0;
    cyc(6);
    chkn("alt pulses", 2, pulses);
    conclude();
  end
endmodule // dtmoc_ctrl_tb
